/* File: logic/ppl_power_led.sv */
// Per-port power-down control and indicator configuration for two ports.
// Assumes all inputs but rst_b_i synchronous to clock_i; the host writes via ports.
//
// Contract
// - First indicator on, second muxed off after reset
// - Second indicator reaches pin only when mux selects
// - Each indicator has own enable, defaults first on
// - Each indicator polarity field, defaults to autosense
// - One-bit blink mode field, defaults mode one
// - Function select defaults link+traffic, traffic only
// - Each indicator blinks from own on/off time
// - Reset pin low holds hardware power-down
// - Power-down gates clocks, pins high impedance
// - Register accesses refused during hardware power-down
// - Soft power-down: low power, PLL stays active
// - Soft power-down ignores line, drops link
// - Registers stay accessible during soft power-down
// - Writing one enters soft power-down
// - Reached status bit set while powered down
// - Clearing bit exits, link after autonegotiation
// - Second port no link while first down
// - Straps sampled right after any reset
// - Shared pins revert to normal use after sampling
// - Unmanaged forwarding defaults to cut-through
// - Host writes override strapped settings
// - Soft power-down exits by host write or by strap reload at reset
// - Power-down bit loaded from strap at reset
// - Strap low means power-down, high means active
`default_nettype none
`include "ppl_params.svh"

module ppl_power_led
    import ppl_pkg::*;
(
    input  wire logic                       clock_i,
    input  wire logic                       rst_b_i,
    input  wire logic                       soft_reset_i,
    // Straps on the shared pins.
    input  wire logic [`PPL_NUM_PORTS-1:0]  port_boot_powerdown_strap_i,
    input  wire logic [`PPL_NUM_PORTS-1:0]  port_first_indicator_pin_i,
    // Host register writes, one per field group per port; forwarding has a single write.
    input  wire logic [`PPL_NUM_PORTS-1:0]  soft_powerdown_wr_i,
    input  wire logic [`PPL_NUM_PORTS-1:0]  soft_powerdown_request_i,
    input  wire logic [`PPL_NUM_PORTS-1:0]  indicator_wr_i,
    input  wire ppl_ind_cfg_t [`PPL_NUM_PORTS-1:0] first_indicator_cfg_i,
    input  wire ppl_ind_cfg_t [`PPL_NUM_PORTS-1:0] second_indicator_cfg_i,
    input  wire logic [1:0]                 second_indicator_mux_sel_i,
    input  wire logic [`PPL_NUM_PORTS-1:0]  mux_wr_i,
    input  wire logic                       forward_store_i,
    input  wire logic                       forward_wr_i,
    // Status from the link side.
    input  wire logic [`PPL_NUM_PORTS-1:0]  autoneg_done_i,
    input  wire logic [`PPL_NUM_PORTS-1:0]  line_activity_i,
    input  wire logic [`PPL_NUM_PORTS-1:0]  traffic_i,
    // Outputs.
    output logic                            reg_access_ok_o,
    output logic                            internal_clk_en_o,
    output logic                            pll_en_o,
    output logic [`PPL_NUM_PORTS-1:0]       soft_powerdown_reached_o,
    output logic [`PPL_NUM_PORTS-1:0]       phy_low_power_o,
    output logic [`PPL_NUM_PORTS-1:0]       link_up_o,
    output logic [`PPL_NUM_PORTS-1:0]       line_rx_en_o,
    output logic                            cut_through_o,
    output logic [`PPL_NUM_PORTS-1:0]       port_first_indicator_pin_o,
    output logic [`PPL_NUM_PORTS-1:0]       port_first_indicator_pin_oe_b_o,
    output logic [`PPL_NUM_PORTS-1:0]       port_second_indicator_pin_o,
    output logic [`PPL_NUM_PORTS-1:0]       port_second_indicator_pin_oe_b_o
);

    ////////////////////////////////////////////////////////////////////////
    // Reset release through two flops; the rest uses the synced copy.
    logic rst_meta_q;
    logic rst_sync_q;

    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rst_meta_q <= 1'b0;
            rst_sync_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_sync_q <= rst_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Boot sequencer: off while reset, one sample cycle, then running.
    ppl_state_t state_q;
    ppl_state_t state_d;
    logic       sampling;
    logic       running;

    always_comb begin
        case (state_q)
            PPL_ST_OFF:    state_d = PPL_ST_SAMPLE;
            PPL_ST_SAMPLE: state_d = PPL_ST_RUN;
            PPL_ST_RUN:    state_d = soft_reset_i ? PPL_ST_SAMPLE : PPL_ST_RUN;
            default:       state_d = PPL_ST_OFF;
        endcase
    end

    // The soft reset re-enters sampling so straps are latched again.
    always_ff @(posedge clock_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            state_q <= PPL_ST_OFF;
        end else begin
            state_q <= state_d;
        end
    end

    assign sampling = (state_q == PPL_ST_SAMPLE);
    assign running  = (state_q == PPL_ST_RUN);

    // Hardware power-down: clocks gated, no register access.
    assign internal_clk_en_o = (state_q != PPL_ST_OFF);
    assign pll_en_o          = internal_clk_en_o;
    assign reg_access_ok_o   = running;

    ////////////////////////////////////////////////////////////////////////
    // Forwarding mode: cut-through unless the host picks store-forward.
    logic store_fwd_q;

    always_ff @(posedge clock_i or negedge rst_sync_q) begin
        if (!rst_sync_q) begin
            store_fwd_q <= 1'b0;
        end else if (sampling) begin
            store_fwd_q <= 1'b0;
        end else if (running && forward_wr_i) begin
            store_fwd_q <= forward_store_i;
        end
    end

    assign cut_through_o = ~store_fwd_q;

    ////////////////////////////////////////////////////////////////////////
    // Per-port power-down and indicator state.
    logic [`PPL_NUM_PORTS-1:0] pd_q;
    logic [`PPL_NUM_PORTS-1:0] link_q;
    logic [`PPL_NUM_PORTS-1:0] sensed_low_q;
    logic [`PPL_NUM_PORTS-1:0] mux_on_q;
    logic [`PPL_NUM_PORTS-1:0] first_drive;
    logic [`PPL_NUM_PORTS-1:0] second_drive;
    ppl_ind_cfg_t [`PPL_NUM_PORTS-1:0] first_cfg_q;
    ppl_ind_cfg_t [`PPL_NUM_PORTS-1:0] second_cfg_q;

    genvar p;
    generate
        for (p = 0; p < `PPL_NUM_PORTS; p = p + 1) begin : g_port
            logic link_allowed;

            // The power-down bit loads from the strap at each reset and
            // afterwards changes only by a host write.
            always_ff @(posedge clock_i or negedge rst_sync_q) begin
                if (!rst_sync_q) begin
                    pd_q[p] <= 1'b1;
                end else if (sampling) begin
                    pd_q[p] <= (port_boot_powerdown_strap_i[p] ==
                                `PPL_STRAP_PD_LEVEL);
                end else if (running && soft_powerdown_wr_i[p]) begin
                    pd_q[p] <= soft_powerdown_request_i[p];
                end
            end

            // Port two waits for port one to leave power-down.
            if (p == 0) begin : g_first
                assign link_allowed = ~pd_q[0];
            end else begin : g_other
                assign link_allowed = ~pd_q[p] & ~pd_q[0];
            end

            // Link comes up only after autonegotiation; drops on power-down.
            always_ff @(posedge clock_i or negedge rst_sync_q) begin
                if (!rst_sync_q) begin
                    link_q[p] <= 1'b0;
                end else if (!running || !link_allowed) begin
                    link_q[p] <= 1'b0;
                end else begin
                    link_q[p] <= autoneg_done_i[p] &
                                 line_activity_i[p];
                end
            end

            // Autosense level is caught in the sampling cycle only.
            always_ff @(posedge clock_i or negedge rst_sync_q) begin
                if (!rst_sync_q) begin
                    sensed_low_q[p] <= 1'b0;
                end else if (sampling) begin
                    sensed_low_q[p] <= ~port_first_indicator_pin_i[p];
                end
            end

            // Reset defaults; a soft reset restores them while sampling.
            localparam ppl_ind_cfg_t FIRST_RST = '{`PPL_FIRST_EN_RST,
                `PPL_POL_AUTO, `PPL_MODE_ONE, `PPL_FUNC_LINK_TRAFFIC,
                `PPL_ON_OFF_TIME_RST};
            localparam ppl_ind_cfg_t SECOND_RST = '{`PPL_SECOND_EN_RST,
                `PPL_POL_AUTO, `PPL_MODE_ONE, `PPL_FUNC_TRAFFIC,
                `PPL_ON_OFF_TIME_RST};

            // The async branch holds only constants; sampling is separate.
            always_ff @(posedge clock_i or negedge rst_sync_q) begin
                if (!rst_sync_q) begin
                    first_cfg_q[p]  <= FIRST_RST;
                    second_cfg_q[p] <= SECOND_RST;
                end else if (sampling) begin
                    first_cfg_q[p]  <= FIRST_RST;
                    second_cfg_q[p] <= SECOND_RST;
                end else if (running && indicator_wr_i[p]) begin
                    first_cfg_q[p]  <= first_indicator_cfg_i[p];
                    second_cfg_q[p] <= second_indicator_cfg_i[p];
                end
            end

            // Second pin is muxed off until the host selects it.
            always_ff @(posedge clock_i or negedge rst_sync_q) begin
                if (!rst_sync_q) begin
                    mux_on_q[p] <= 1'b0;
                end else if (sampling) begin
                    mux_on_q[p] <= 1'b0;
                end else if (running && mux_wr_i[p]) begin
                    mux_on_q[p] <= (second_indicator_mux_sel_i ==
                                    `PPL_MUX_INDICATOR);
                end
            end

            ppl_indicator u_first (
                .clock_i      (clock_i),
                .rst_b_i      (rst_sync_q),
                .cfg_i        (first_cfg_q[p]),
                .link_up_i    (link_q[p]),
                .traffic_i    (traffic_i[p]),
                .sensed_low_i (sensed_low_q[p]),
                .drive_o      (first_drive[p])
            );

            ppl_indicator u_second (
                .clock_i      (clock_i),
                .rst_b_i      (rst_sync_q),
                .cfg_i        (second_cfg_q[p]),
                .link_up_i    (link_q[p]),
                .traffic_i    (traffic_i[p]),
                .sensed_low_i (1'b1), // Pulled-down pin reads low.
                .drive_o      (second_drive[p])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Status and pin outputs; pins float until sampling is over.
    assign soft_powerdown_reached_o =
        pd_q & {`PPL_NUM_PORTS{running}};
    assign phy_low_power_o  = pd_q | {`PPL_NUM_PORTS{~running}};
    assign line_rx_en_o     = ~phy_low_power_o;
    assign link_up_o        = link_q;
    assign port_first_indicator_pin_o = first_drive;
    assign port_second_indicator_pin_o = second_drive;
    // Active-low enables; high keeps the pin tristate for strap reading.
    assign port_first_indicator_pin_oe_b_o =
        {`PPL_NUM_PORTS{~running}};
    assign port_second_indicator_pin_oe_b_o =
        ~(mux_on_q & {`PPL_NUM_PORTS{running}});

endmodule

`default_nettype wire

/* File: logic/ppl_params.svh */
// Constants for the port power and indicator configuration block.
// Assumes inclusion by bare name from the package and design modules.
`ifndef PPL_PARAMS_SVH
`define PPL_PARAMS_SVH

`define PPL_NUM_PORTS        2
`define PPL_FUNC_W           4
`define PPL_TIME_W           16
`define PPL_POL_AUTO         2'h0
`define PPL_POL_HIGH         2'h1
`define PPL_POL_LOW          2'h2
`define PPL_MODE_ONE         1'h0
`define PPL_MODE_TWO         1'h1
`define PPL_FUNC_LINK_TRAFFIC 4'h0
`define PPL_FUNC_TRAFFIC     4'h1
`define PPL_FUNC_BAD_LO      4'h7
`define PPL_FUNC_BAD_HI      4'ha
`define PPL_MUX_OFF          2'h0
`define PPL_MUX_INDICATOR    2'h1
`define PPL_FIRST_EN_RST     1'h1
`define PPL_SECOND_EN_RST    1'h0
`define PPL_ON_OFF_TIME_RST  16'h0808
`define PPL_STRAP_PD_LEVEL   1'h0

`endif

/* File: logic/ppl_pkg.sv */
// Types shared by the power and indicator configuration modules.
// Assumes ppl_params.svh is on the include path.
`default_nettype none
`include "ppl_params.svh"

package ppl_pkg;

    // Configuration of one indicator output.
    typedef struct packed {
        logic                     enable;
        logic [1:0]               polarity;
        logic                     blink_mode;
        logic [`PPL_FUNC_W-1:0]   function_sel;
        logic [`PPL_TIME_W-1:0]   on_off_time;
    } ppl_ind_cfg_t;

    // Boot sequencing states shared by both ports.
    typedef enum logic [1:0] {
        PPL_ST_OFF,
        PPL_ST_SAMPLE,
        PPL_ST_RUN
    } ppl_state_t;

endpackage

`default_nettype wire

/* File: logic/ppl_indicator.sv */
// One indicator output: blink timer, function gate and polarity drive.
// Assumes the event inputs are synchronous to clock_i.
`default_nettype none
`include "ppl_params.svh"

module ppl_indicator
    import ppl_pkg::*;
(
    input  wire logic         clock_i,
    input  wire logic         rst_b_i,
    input  wire ppl_ind_cfg_t cfg_i,
    input  wire logic         link_up_i,
    input  wire logic         traffic_i,
    input  wire logic         sensed_low_i,
    output logic              drive_o
);

    logic [`PPL_TIME_W-1:0] cnt_q;
    logic                   blink_q;
    logic                   func_ok;
    logic                   active;
    logic                   lit;
    logic                   active_low;

    ////////////////////////////////////////////////////////////////////////
    // Blink timer: upper byte is on time, lower byte is off time.
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cnt_q   <= '0;
            blink_q <= 1'b0;
        end else if (cnt_q == '0) begin
            blink_q <= ~blink_q;
            cnt_q   <= blink_q ? {8'h00, cfg_i.on_off_time[7:0]}
                               : {8'h00, cfg_i.on_off_time[15:8]};
        end else begin
            cnt_q <= cnt_q - 16'h0001;
        end
    end

    // Unsupported codes in the second mode leave the output dark.
    assign func_ok = !(cfg_i.blink_mode == `PPL_MODE_TWO &&
                       cfg_i.function_sel >= `PPL_FUNC_BAD_LO &&
                       cfg_i.function_sel <= `PPL_FUNC_BAD_HI);

    // Function decode; the second mode blinks at the timer rate too.
    always_comb begin
        case (cfg_i.function_sel)
            `PPL_FUNC_LINK_TRAFFIC: active = link_up_i &
                                            (traffic_i ? blink_q : 1'b1);
            `PPL_FUNC_TRAFFIC:      active = traffic_i & blink_q;
            default:                active = link_up_i;
        endcase
    end

    assign lit = cfg_i.enable & func_ok & active;

    // Autosense follows the level seen when the pin was sampled.
    assign active_low = (cfg_i.polarity == `PPL_POL_LOW) ||
                        (cfg_i.polarity == `PPL_POL_AUTO &&
                         !sensed_low_i);
    assign drive_o = active_low ? ~lit : lit;

endmodule

`default_nettype wire

/* File: dv/ppl_power_led_assertions.sv */
// Checker for the port power and indicator block, bound to its top ports.
// Assumes the raw reset pin is visible; the block syncs it internally.
`default_nettype none

module ppl_power_led_assertions (
    input wire logic       clock_i,
    input wire logic       rst_b_i,
    input wire logic       soft_reset_i,
    input wire logic [1:0] soft_powerdown_wr_i,
    input wire logic [1:0] soft_powerdown_request_i,
    input wire logic       forward_store_i,
    input wire logic       forward_wr_i,
    input wire logic [1:0] autoneg_done_i,
    input wire logic       reg_access_ok_o,
    input wire logic       internal_clk_en_o,
    input wire logic       pll_en_o,
    input wire logic [1:0] soft_powerdown_reached_o,
    input wire logic [1:0] phy_low_power_o,
    input wire logic [1:0] link_up_o,
    input wire logic [1:0] line_rx_en_o,
    input wire logic       cut_through_o,
    input wire logic [1:0] port_first_indicator_pin_oe_b_o,
    input wire logic [1:0] port_second_indicator_pin_oe_b_o
);
    // One clock domain, so clock and disable are given once.
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_b_i);

    ////////////////////////////////////////////////////////////////////////
    property p_clk_run;
        reg_access_ok_o |-> internal_clk_en_o && pll_en_o;
    endproperty
    a_clk_run: assert property (p_clk_run)
        else $error("clocks gated while running");
    property p_wr_pd;
        reg_access_ok_o && soft_powerdown_wr_i[0] && !soft_reset_i |=>
            soft_powerdown_reached_o[0] == $past(soft_powerdown_request_i[0]);
    endproperty
    a_wr_pd: assert property (p_wr_pd)
        else $error("power-down write not taken");
    // Without a write the bit must never move on its own.
    property p_hold_pd;
        reg_access_ok_o && !soft_powerdown_wr_i[1] && !soft_reset_i
            ##1 reg_access_ok_o |-> $stable(soft_powerdown_reached_o[1]);
    endproperty
    a_hold_pd: assert property (p_hold_pd)
        else $error("power-down bit changed without write");
    property p_lp;
        reg_access_ok_o |-> phy_low_power_o == soft_powerdown_reached_o;
    endproperty
    a_lp: assert property (p_lp)
        else $error("low power differs from status");
    property p_rx;
        line_rx_en_o == ~phy_low_power_o;
    endproperty
    a_rx: assert property (p_rx)
        else $error("line receive enabled in low power");
    property p_drop;
        phy_low_power_o[0] [*2] |-> !link_up_o[0];
    endproperty
    a_drop: assert property (p_drop)
        else $error("link kept in power-down");
    property p_order;
        phy_low_power_o[0] [*2] |-> !link_up_o[1];
    endproperty
    a_order: assert property (p_order)
        else $error("second link while first powered down");
    property p_link;
        $rose(link_up_o[1]) |->
            $past(autoneg_done_i[1]) && !$past(phy_low_power_o[1]);
    endproperty
    a_link: assert property (p_link)
        else $error("link rose without autonegotiation");
    property p_cut;
        reg_access_ok_o && forward_wr_i && !soft_reset_i |=>
            cut_through_o != $past(forward_store_i);
    endproperty
    a_cut: assert property (p_cut)
        else $error("forwarding write not taken");
    property p_mux_off;
        !reg_access_ok_o |-> port_second_indicator_pin_oe_b_o == 2'h3;
    endproperty
    a_mux_off: assert property (p_mux_off)
        else $error("second indicator driven before run");
    property p_first_on;
        reg_access_ok_o |-> port_first_indicator_pin_oe_b_o == 2'h0;
    endproperty
    a_first_on: assert property (p_first_on)
        else $error("first indicator not driven");

    // Main scenarios.
    c_exit: cover property ($fell(soft_powerdown_reached_o[0]));
    c_link: cover property ($rose(link_up_o[1]));
    c_mux: cover property ($fell(port_second_indicator_pin_oe_b_o[1]));
endmodule

`default_nettype wire

/* File: dv/ppl_host_model.sv */
// Host model: turns register writes into one-cycle write pulses.
// Callers may also write while the block refuses writes; such writes are lost.
`default_nettype none
`include "ppl_params.svh"

module ppl_host_model
    import ppl_pkg::*;
(
    input  wire logic          clock_i,
    output ppl_ind_cfg_t [1:0] cfg_o,
    output logic [1:0]         pd_wr_o,
    output logic [1:0]         pd_req_o,
    output logic [1:0]         ind_wr_o,
    output logic [1:0]         mux_sel_o,
    output logic [1:0]         mux_wr_o,
    output logic               fwd_store_o,
    output logic               fwd_wr_o
);
    timeunit 1ns;
    timeprecision 1ns;

    ////////////////////////////////////////////////////////////////////////
    // Idle values at time zero; data is inverted once released so that a
    // stale value can never pass for a fresh one.
    initial begin
        cfg_o = '0;
        {pd_wr_o, pd_req_o, ind_wr_o, mux_sel_o, mux_wr_o} = '0;
        {fwd_store_o, fwd_wr_o} = '0;
    end

    task automatic write_pd(input int p, input logic v);
        @(negedge clock_i);
        pd_req_o[p] = v;
        pd_wr_o[p] = 1'b1;
        @(negedge clock_i);
        pd_wr_o[p] = 1'b0;
        pd_req_o[p] = ~v;
    endtask

    // Both indicators of a port get the same settings.
    task automatic write_ind(input int p, input ppl_ind_cfg_t c);
        if (c.blink_mode == `PPL_MODE_TWO && c.function_sel inside
            {[`PPL_FUNC_BAD_LO:`PPL_FUNC_BAD_HI]}) begin
            c.function_sel = `PPL_FUNC_TRAFFIC;
        end
        @(negedge clock_i);
        cfg_o[p] = c;
        ind_wr_o[p] = 1'b1;
        @(negedge clock_i);
        ind_wr_o[p] = 1'b0;
        cfg_o[p] = ~c;
    endtask

    task automatic write_mux(input int p, input logic [1:0] v);
        @(negedge clock_i);
        mux_sel_o = v;
        mux_wr_o[p] = 1'b1;
        @(negedge clock_i);
        mux_wr_o[p] = 1'b0;
        mux_sel_o = ~v;
    endtask

    task automatic write_fwd(input logic v);
        @(negedge clock_i);
        fwd_store_o = v;
        fwd_wr_o = 1'b1;
        @(negedge clock_i);
        fwd_wr_o = 1'b0;
        fwd_store_o = ~v;
    endtask
endmodule

`default_nettype wire

/* File: dv/ppl_power_led_test.sv */
// Bench for the port power and indicator block with a host model.
// Assumes the design files and ppl_params.svh are compiled first.
`default_nettype none
`include "ppl_params.svh"

`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin failures++; \
    $display("FAIL %0t mismatch at line %0d", $time, `__LINE__); end end

module ppl_power_led_test
    import ppl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clock_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic soft_reset_i = 1'b0;
    logic [1:0] strap = 2'h2;
    logic [1:0] autoneg = 2'h0;
    logic [1:0] line_act = 2'h0;
    logic [1:0] traffic = 2'h0;
    logic [1:0] sense_pin = 2'h0;
    ppl_ind_cfg_t [1:0] cfg;
    logic [1:0] pd_wr, pd_req, ind_wr, mux_sel, mux_wr;
    logic fwd_store, fwd_wr, reg_access_ok_o, internal_clk_en_o, pll_en_o;
    logic cut_through_o;
    logic [1:0] soft_powerdown_reached_o, phy_low_power_o, link_up_o;
    logic [1:0] line_rx_en_o, first_pin, first_oe_b, second_pin, second_oe_b;
    int failures = 0;
    int n_tests = 0;

    always #25 clock_i = ~clock_i;

    ////////////////////////////////////////////////////////////////////////
    ppl_host_model u_host (.clock_i, .cfg_o(cfg), .pd_wr_o(pd_wr),
        .pd_req_o(pd_req), .ind_wr_o(ind_wr), .mux_sel_o(mux_sel),
        .mux_wr_o(mux_wr), .fwd_store_o(fwd_store), .fwd_wr_o(fwd_wr));

    // Autosense reads sense_pin: a low level selects active high drive.
    ppl_power_led u_dut (.clock_i, .rst_b_i, .soft_reset_i,
        .port_boot_powerdown_strap_i(strap),
        .port_first_indicator_pin_i(sense_pin),
        .soft_powerdown_wr_i(pd_wr), .soft_powerdown_request_i(pd_req),
        .indicator_wr_i(ind_wr), .first_indicator_cfg_i(cfg),
        .second_indicator_cfg_i(cfg), .second_indicator_mux_sel_i(mux_sel),
        .mux_wr_i(mux_wr), .forward_store_i(fwd_store),
        .forward_wr_i(fwd_wr), .autoneg_done_i(autoneg),
        .line_activity_i(line_act), .traffic_i(traffic), .reg_access_ok_o,
        .internal_clk_en_o, .pll_en_o, .soft_powerdown_reached_o,
        .phy_low_power_o, .link_up_o, .line_rx_en_o, .cut_through_o,
        .port_first_indicator_pin_o(first_pin),
        .port_first_indicator_pin_oe_b_o(first_oe_b),
        .port_second_indicator_pin_o(second_pin),
        .port_second_indicator_pin_oe_b_o(second_oe_b));

    task automatic end_of_test();
        if (failures == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic wait_ok();
        for (int i = 0; i < 20 && reg_access_ok_o !== 1'b1; i++)
            @(negedge clock_i);
        `CHK(reg_access_ok_o, 1'b1)
    endtask

    // Loads port 1 indicators and checks both pins settle to e.
    task automatic set_ind(input logic [1:0] pol, input logic en,
                           input logic e);
        u_host.write_ind(1, '{en, pol, `PPL_MODE_ONE, 4'h2,
                              16'h0808});
        repeat (3) @(negedge clock_i);
        `CHK(first_pin[1], e)
        `CHK(second_pin[1], e)
    endtask

    // A hang is cut short well past the expected run of under a hundred cycles.
    initial begin
        #50us;
        failures++;
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////
    initial begin
        int cnt;
        // Reset spans two edges; the write made inside it must be lost.
        u_host.write_pd(1, 1'b1);
        `CHK(reg_access_ok_o, 1'b0)
        `CHK(internal_clk_en_o, 1'b0)
        `CHK(first_oe_b, 2'h3)
        rst_b_i = 1'b1;
        wait_ok();
        `CHK(soft_powerdown_reached_o, 2'h1)
        `CHK(phy_low_power_o, 2'h1)
        `CHK(cut_through_o, 1'b1)
        `CHK(second_oe_b, 2'h3)
        `CHK(pll_en_o, 1'b1)
        autoneg = 2'h3;
        line_act = 2'h3;
        repeat (6) @(negedge clock_i);
        `CHK(link_up_o, 2'h0)
        `CHK(line_rx_en_o, 2'h2)
        u_host.write_pd(0, 1'b0);
        repeat (3) @(negedge clock_i);
        `CHK(soft_powerdown_reached_o, 2'h0)
        `CHK(link_up_o, 2'h3)
        `CHK(first_pin, 2'h3)
        u_host.write_mux(1, `PPL_MUX_INDICATOR);
        set_ind(`PPL_POL_HIGH, 1'b1, 1'b1);
        `CHK(second_oe_b, 2'h1)
        set_ind(`PPL_POL_LOW, 1'b1, 1'b0);
        set_ind(`PPL_POL_HIGH, 1'b0, 1'b0);
        // Mode two with a code it supports still shows the link level.
        u_host.write_ind(1, '{1'b1, `PPL_POL_HIGH, `PPL_MODE_TWO, 4'h2,
                              16'h0808});
        repeat (3) @(negedge clock_i);
        `CHK(first_pin[1], 1'b1)
        traffic = 2'h3;
        u_host.write_ind(1, '{1'b1, `PPL_POL_HIGH, `PPL_MODE_ONE,
                              `PPL_FUNC_TRAFFIC, 16'h0303});
        // The old period must run out before lit cycles are counted.
        repeat (10) @(negedge clock_i);
        cnt = 0;
        repeat (24) begin
            @(negedge clock_i);
            cnt += first_pin[1];
        end
        `CHK(cnt, 12)
        u_host.write_pd(0, 1'b1);
        repeat (3) @(negedge clock_i);
        `CHK(link_up_o, 2'h0)
        `CHK(soft_powerdown_reached_o, 2'h1)
        u_host.write_fwd(1'b1);
        @(negedge clock_i);
        `CHK(cut_through_o, 1'b0)
        // Soft reset: straps swap and port 2 senses a high pin level.
        strap = 2'h1;
        sense_pin = 2'h2;
        traffic = 2'h0;
        soft_reset_i = 1'b1;
        @(negedge clock_i);
        soft_reset_i = 1'b0;
        repeat (2) @(negedge clock_i);
        wait_ok();
        `CHK(soft_powerdown_reached_o, 2'h2)
        `CHK(cut_through_o, 1'b1)
        `CHK(second_oe_b, 2'h3)
        `CHK(link_up_o, 2'h1)
        `CHK(first_pin, 2'h3)
        `CHK(second_pin, 2'h0)
        end_of_test();
    end
endmodule

bind ppl_power_led ppl_power_led_assertions u_chk (.clock_i, .rst_b_i,
    .soft_reset_i, .soft_powerdown_wr_i, .soft_powerdown_request_i,
    .forward_store_i, .forward_wr_i, .autoneg_done_i, .reg_access_ok_o,
    .internal_clk_en_o, .pll_en_o, .soft_powerdown_reached_o,
    .phy_low_power_o, .link_up_o, .line_rx_en_o, .cut_through_o,
    .port_first_indicator_pin_oe_b_o, .port_second_indicator_pin_oe_b_o);

`default_nettype wire
